// file: src/ddn_unit.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - after full subtract, success qualifier high and another subtract follows
// - failed subtract shifts numerator one digit and retries
// - failed subtract shifts counter value into quotient register
// - count clock pulses per success; counter accumulates until failure
// - count clock also steps counter during annunciator search
// - quotient clock enable lets shift clock enter one digit
// - remote multiplier: shift point and count until equal; qualifier low
// - clear command zeroes the quotient multiplier counter
// - active-high qualifier when counter is zero
// - active-low qualifier at count six
// - active-low qualifier at count nine
// - active-low qualifier at count ten; divisor and point shift left
// - active-low qualifier for blank digit during quotient output
// - busy low during processing; plug-in data blocked then
// - transmit strobe low loads divisor from plug-in; internal sign off
// - remote control low selects remote multiplier code
// - numerator and counter both zero marks first quotient digit
// - numerator clock enable lets shift clock advance numerator
module ddn_unit
   import ddn_pkg::*;
#(
   parameter int DIGITS = NUM_DIGITS
)(
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        plugin_transmit_strobe_n,
   input  wire logic [63:0] plugin_data,
   input  wire logic [3:0]  plugin_dp,
   input  wire logic        plugin_sign_minus,
   input  wire logic        remote_control_n,
   input  wire logic [3:0]  remote_multiplier_code,
   output logic             processor_busy_n,
   output logic             sign_minus_n,
   output logic             subtract_success,
   output logic             count_zero,
   output logic             count_six_n,
   output logic             count_nine_n,
   output logic             count_ten_n,
   output logic             count_equals_stored_multiplier_n,
   output logic             first_digit,
   output logic             quotient_digit_blank_n
);
   localparam int W = 4*DIGITS;
   ddn_state_t state_r, state_nxt;
   logic [W-1:0] numer_r, divis_r, quot_r;
   logic [3:0]   quotCount_r, localMult_r, storedMult_r, dp_r, outIdx_r;
   logic         ctlMinus_r, ack_r, success_r;
   logic         sgnMinus_r, blank_r;
   logic         zeroQ, sixQ, nineQ, tenQ, eqQ, firstQ;
   logic [W-1:0] diff;
   logic         noBorrow;
   ddn_bcd_sub #(.DIGITS(DIGITS)) u_sub (
      .minuend    (numer_r),
      .subtrahend (divis_r),
      .difference (diff),
      .noBorrow   (noBorrow)
   );
   wire [3:0] multSrc = remote_control_n ? localMult_r : remote_multiplier_code;
   wire       numerZero = (numer_r == '0);
   ddn_qual u_qual (
      .quotCount     (quotCount_r),
      .storedMult    (storedMult_r),
      .numerZero     (numerZero),
      .countZero     (zeroQ),
      .countSix_n    (sixQ),
      .countNine_n   (nineQ),
      .countTen_n    (tenQ),
      .countEqMult_n (eqQ),
      .firstDigit    (firstQ)
   );
   wire busReq   = (avs_read | avs_write) & ~ack_r;
   wire wrStrobe = avs_write & ack_r;
   wire idle     = (state_r == DDN_IDLE) | (state_r == DDN_DONE);
   wire wrCtrl   = wrStrobe & (avs_address == ADDR_CTRL);
   wire startCmd = wrCtrl & avs_writedata[CTRL_START_BIT] & idle;
   wire clearCmd = wrCtrl & avs_writedata[CTRL_CLEAR_BIT];
   wire alignCmd = wrCtrl & avs_writedata[CTRL_ALIGN_BIT] & idle;
   wire annunCmd = wrCtrl & avs_writedata[CTRL_ANNUN_BIT] & idle;
   // plug-in load only while not busy
   wire piLoad   = ~plugin_transmit_strobe_n & idle;
   wire [31:0] statusWord = {20'h0, dp_r, quotCount_r, firstQ, zeroQ, success_r, ~idle};
   wire [31:0] rdMux =
      (avs_address == ADDR_STATUS)   ? statusWord :
      (avs_address == ADDR_NUMER_LO) ? numer_r[31:0] :
      (avs_address == ADDR_NUMER_HI) ? numer_r[63:32] :
      (avs_address == ADDR_DIVIS_LO) ? divis_r[31:0] :
      (avs_address == ADDR_DIVIS_HI) ? divis_r[63:32] :
      (avs_address == ADDR_QUOT_LO)  ? quot_r[31:0] :
      (avs_address == ADDR_QUOT_HI)  ? quot_r[63:32] :
      (avs_address == ADDR_MULT)     ? {24'h0, dp_r, storedMult_r} :
      RESET_WORD;
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         DDN_IDLE, DDN_DONE:
         begin
            if (startCmd)
               state_nxt = DDN_SUB;
            else if (alignCmd)
               state_nxt = DDN_ALIGN;
            else if (annunCmd)
               state_nxt = DDN_ANNUN;
         end
         DDN_SUB:
            state_nxt = noBorrow ? DDN_SUB : DDN_SHIFT;
         DDN_SHIFT:
            state_nxt = (outIdx_r == 4'(DIGITS-1)) ? DDN_DONE : DDN_SUB;
         DDN_ALIGN:
            state_nxt = eqQ ? DDN_ALIGN : DDN_DONE;
         DDN_ANNUN:
            state_nxt = (sixQ && eqQ) ? DDN_ANNUN : DDN_DONE;
         default:
            state_nxt = DDN_IDLE;
      endcase
   end
   wire subOk    = (state_r == DDN_SUB) & noBorrow;
   wire subFail  = (state_r == DDN_SUB) & ~noBorrow;
   wire countClk = subOk | ((state_r == DDN_ALIGN) & eqQ) |
                   ((state_r == DDN_ANNUN) & sixQ & eqQ);
   wire tenShift = subOk & ~tenQ;
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         state_r <= DDN_IDLE;
      else
         state_r <= state_nxt;
   end
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         quotCount_r <= 4'h0;
      else if (clearCmd || startCmd || (state_r == DDN_SHIFT))
         quotCount_r <= 4'h0;
      else if (countClk)
         quotCount_r <= quotCount_r + 4'h1;
   end
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         numer_r <= '0;
      else if (wrStrobe && avs_address == ADDR_NUMER_LO)
         numer_r[31:0] <= avs_writedata;
      else if (wrStrobe && avs_address == ADDR_NUMER_HI)
         numer_r[63:32] <= avs_writedata;
      else if (subOk)
         numer_r <= diff;
      else if (subFail)
         numer_r <= {numer_r[W-5:0], 4'h0};
   end
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         divis_r <= '0;
      else if (piLoad)
         divis_r <= plugin_data;
      else if (wrStrobe && avs_address == ADDR_DIVIS_LO)
         divis_r[31:0] <= avs_writedata;
      else if (wrStrobe && avs_address == ADDR_DIVIS_HI)
         divis_r[63:32] <= avs_writedata;
      else if (tenShift)
         divis_r <= {divis_r[W-5:0], 4'h0};
   end
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         quot_r <= '0;
      else if (startCmd)
         quot_r <= '0;
      else if (subFail)
         quot_r <= {quot_r[W-5:0], quotCount_r};
   end
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         outIdx_r <= 4'h0;
      else if (startCmd)
         outIdx_r <= 4'h0;
      else if (state_r == DDN_SHIFT)
         outIdx_r <= outIdx_r + 4'h1;
   end
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         dp_r        <= 4'h0;
         localMult_r <= 4'h0;
      end
      else if (piLoad)
         dp_r <= plugin_dp;
      else if (wrStrobe && avs_address == ADDR_MULT)
      begin
         localMult_r <= avs_writedata[MULT_CODE_LSB +: 4];
         dp_r        <= avs_writedata[MULT_DP_LSB +: 4];
      end
      else if (((state_r == DDN_ALIGN) && eqQ) || tenShift)
         dp_r <= dp_r + 4'h1;
   end
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         storedMult_r <= 4'h0;
      else
         storedMult_r <= multSrc;
   end
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         ctlMinus_r <= 1'b0;
      else if (wrStrobe && avs_address == ADDR_MULT)
         ctlMinus_r <= avs_writedata[8];
   end
   // bus slave: one wait cycle, answer on second edge
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         ack_r        <= 1'b0;
         avs_readdata <= RESET_WORD;
      end
      else
      begin
         ack_r        <= busReq;
         avs_readdata <= rdMux;
      end
   end
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         {success_r, sgnMinus_r, blank_r} <= 3'h0;
      else
      begin
         if (state_r == DDN_SUB)
            success_r <= noBorrow;
         sgnMinus_r <= plugin_transmit_strobe_n ? ctlMinus_r : plugin_sign_minus;
         blank_r    <= (quot_r[3:0] == DIGIT_BLANK);
      end
   end
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         {subtract_success, first_digit} <= 2'h0;
         {processor_busy_n, sign_minus_n, count_zero, count_six_n, count_nine_n, count_ten_n,
          count_equals_stored_multiplier_n, quotient_digit_blank_n, avs_waitrequest} <= 9'h1FF;
      end
      else
      begin
         subtract_success                 <= (state_r == DDN_SUB) ? noBorrow : success_r;
         processor_busy_n                 <= idle;
         sign_minus_n                     <= ~sgnMinus_r;
         count_zero                       <= zeroQ;
         count_six_n                      <= sixQ;
         count_nine_n                     <= nineQ;
         count_ten_n                      <= tenQ;
         count_equals_stored_multiplier_n <= eqQ;
         first_digit                      <= firstQ;
         quotient_digit_blank_n           <= ~blank_r;
         avs_waitrequest                  <= ~busReq;
      end
   end
   default clocking cbAssert @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   property p_sub_retry;
      (state_r == DDN_SUB && noBorrow) |=> (state_r == DDN_SUB);
   endproperty
   a_sub_retry: assert property (p_sub_retry) else $error("success not retried");
   property p_shift_numer;
      subFail |=> (numer_r == {$past(numer_r[W-5:0]), 4'h0});
   endproperty
   a_shift_numer: assert property (p_shift_numer) else $error("numerator not shifted");
   property p_quot_load;
      (subFail && !startCmd) |=> (quot_r[3:0] == $past(quotCount_r));
   endproperty
   a_quot_load: assert property (p_quot_load) else $error("count not moved");
   property p_count_step;
      (subOk && !clearCmd) |=> (quotCount_r == $past(quotCount_r) + 4'h1);
   endproperty
   a_count_step: assert property (p_count_step) else $error("count not stepped");
   property p_clear;
      clearCmd |=> (quotCount_r == 4'h0);
   endproperty
   a_clear: assert property (p_clear) else $error("clear failed");
   property p_zero_q;
      (quotCount_r == 4'h0) |=> count_zero;
   endproperty
   a_zero_q: assert property (p_zero_q) else $error("zero qualifier wrong");
   property p_six_q;
      (quotCount_r == COUNT_SIX) |=> !count_six_n;
   endproperty
   a_six_q: assert property (p_six_q) else $error("six qualifier wrong");
   property p_nine_q;
      (quotCount_r != COUNT_NINE) |=> count_nine_n;
   endproperty
   a_nine_q: assert property (p_nine_q) else $error("nine qualifier wrong");
   property p_busy;
      startCmd |=> ##1 !processor_busy_n;
   endproperty
   a_busy: assert property (p_busy) else $error("busy not low");
endmodule : ddn_unit
`default_nettype wire

// file: src/ddn_pkg.sv
package ddn_pkg;
   // register map (Avalon word offsets as byte addresses)
   localparam logic [7:0] ADDR_CTRL      = 8'h00;
   localparam logic [7:0] ADDR_STATUS    = 8'h04;
   localparam logic [7:0] ADDR_NUMER_LO  = 8'h08;
   localparam logic [7:0] ADDR_NUMER_HI  = 8'h0C;
   localparam logic [7:0] ADDR_DIVIS_LO  = 8'h10;
   localparam logic [7:0] ADDR_DIVIS_HI  = 8'h14;
   localparam logic [7:0] ADDR_QUOT_LO   = 8'h18;
   localparam logic [7:0] ADDR_QUOT_HI   = 8'h1C;
   localparam logic [7:0] ADDR_MULT      = 8'h20;
   // control fields
   localparam int CTRL_START_BIT  = 0;
   localparam int CTRL_CLEAR_BIT  = 1;
   localparam int CTRL_ALIGN_BIT  = 2;
   localparam int CTRL_ANNUN_BIT  = 3;
   localparam int MULT_CODE_LSB   = 0;
   localparam int MULT_DP_LSB     = 4;
   // reset values and fixed figures
   localparam logic [31:0] RESET_WORD   = 32'h0000_0000;
   localparam logic [3:0]  DIGIT_BLANK  = 4'hF;
   localparam logic [3:0]  COUNT_SIX    = 4'h6;
   localparam logic [3:0]  COUNT_NINE   = 4'h9;
   localparam logic [3:0]  COUNT_TEN    = 4'hA;
   localparam int          NUM_DIGITS   = 16;
   localparam int          ACK_DELAY    = 1;
   typedef enum {
      DDN_IDLE,
      DDN_SUB,
      DDN_SHIFT,
      DDN_ALIGN,
      DDN_ANNUN,
      DDN_DONE
   } ddn_state_t;
endpackage : ddn_pkg

// file: src/ddn_bcd_sub.sv
`timescale 1ns/1ps
`default_nettype none
// 16-digit BCD subtract: difference and no-borrow flag
module ddn_bcd_sub
   import ddn_pkg::*;
#(
   parameter int DIGITS = NUM_DIGITS
)(
   input  wire logic [4*DIGITS-1:0] minuend,
   input  wire logic [4*DIGITS-1:0] subtrahend,
   output logic      [4*DIGITS-1:0] difference,
   output logic                     noBorrow
);
   logic [DIGITS:0] borrow;
   assign borrow[0] = 1'b0;
   genvar g;
   generate
      for (g = 0; g < DIGITS; g++)
      begin : g_dig
         logic [4:0] raw;
         assign raw = {1'b0, minuend[4*g +: 4]} - {1'b0, subtrahend[4*g +: 4]}
                      - {4'h0, borrow[g]};
         assign borrow[g+1] = raw[4];
         assign difference[4*g +: 4] = raw[4] ? (raw[3:0] - 4'h6) : raw[3:0];
      end
   endgenerate
   assign noBorrow = ~borrow[DIGITS];
endmodule : ddn_bcd_sub
`default_nettype wire

// file: src/ddn_qual.sv
`timescale 1ns/1ps
`default_nettype none
// qualifiers derived from the quotient multiplier count
module ddn_qual
   import ddn_pkg::*;
(
   input  wire logic [3:0] quotCount,
   input  wire logic [3:0] storedMult,
   input  wire logic       numerZero,
   output logic            countZero,
   output logic            countSix_n,
   output logic            countNine_n,
   output logic            countTen_n,
   output logic            countEqMult_n,
   output logic            firstDigit
);
   assign countZero     = (quotCount == 4'h0);
   assign countSix_n    = ~(quotCount == COUNT_SIX);
   assign countNine_n   = ~(quotCount == COUNT_NINE);
   assign countTen_n    = ~(quotCount == COUNT_TEN);
   assign countEqMult_n = ~(quotCount == storedMult);
   assign firstDigit    = numerZero & countZero;
endmodule : ddn_qual
`default_nettype wire

// file: bench/ddn_plugin_model.sv
`timescale 1ns/1ps
`default_nettype none
// plug-in side: offers divisor data only while the processor is idle
module ddn_plugin_model
(
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        busy_n,
   input  wire logic        sendReq,
   input  wire logic [63:0] sendData,
   input  wire logic [3:0]  sendDp,
   input  wire logic        sendMinus,
   output logic             strobe_n,
   output logic [63:0]      data,
   output logic [3:0]       dp,
   output logic             signMinus
);
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         strobe_n  <= 1'b1;
         data      <= 64'h0;
         dp        <= 4'h0;
         signMinus <= 1'b0;
      end
      // strobe high while busy or not requested; data, dp and sign invert each cycle
      else if (!busy_n || !sendReq)
      begin
         strobe_n  <= 1'b1;
         data      <= ~data;
         dp        <= ~dp;
         signMinus <= ~signMinus;
      end
      else
      begin
         strobe_n  <= 1'b0;
         data      <= sendData;
         dp        <= sendDp;
         signMinus <= sendMinus;
      end
   end
endmodule : ddn_plugin_model
`default_nettype wire

// file: bench/ddn_unit_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
   $display("unexpected %s expected %h seen %h", nm, e, g); end end
module ddn_unit_tb;
   import ddn_pkg::*;
   logic        clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic [7:0]  avsAddress = 8'h00;
   logic        avsRead = 1'b0;
   logic        avsWrite = 1'b0;
   logic [31:0] avsWritedata = 32'h0;
   logic [31:0] avsReaddata;
   logic        avsWaitrequest;
   logic        strobeN, plMinus, rmtN = 1'b1, sendReq = 1'b0, sendMinus = 1'b0;
   logic [63:0] plData, sendData = 64'h0;
   logic [3:0]  plDp, rmtCode = 4'h0;
   logic        busyN, signN, succ, cZero, cSix, cNine, cTen, cEq, firstDig, blankN;
   logic        sawSucc = 1'b0, sawNine = 1'b0, sawTen = 1'b0;
   logic [31:0] rd, seed = 32'h3222;
   logic [63:0] q64;
   int          n_fail = 0, total_checks = 0, k;
   longint      nv, dv;
   always #2.5 clk = ~clk;
   always @(posedge clk)
   begin
      sawSucc <= sawSucc | (succ === 1'b1);
      sawNine <= sawNine | (cNine === 1'b0);
      sawTen  <= sawTen | (cTen === 1'b0);
   end
   ddn_unit ddn_unit_inst (.clk(clk), .sys_rst(sys_rst), .avs_address(avsAddress),
      .avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsWritedata),
      .avs_byteenable(4'hF), .avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest),
      .plugin_transmit_strobe_n(strobeN), .plugin_data(plData), .plugin_dp(plDp),
      .plugin_sign_minus(plMinus), .remote_control_n(rmtN), .remote_multiplier_code(rmtCode),
      .processor_busy_n(busyN), .sign_minus_n(signN), .subtract_success(succ),
      .count_zero(cZero), .count_six_n(cSix), .count_nine_n(cNine), .count_ten_n(cTen),
      .count_equals_stored_multiplier_n(cEq), .first_digit(firstDig),
      .quotient_digit_blank_n(blankN));
   ddn_plugin_model ddn_plugin_model_inst (.clk(clk), .sys_rst(sys_rst), .busy_n(busyN),
      .sendReq(sendReq), .sendData(sendData), .sendDp(4'h3), .sendMinus(sendMinus),
      .strobe_n(strobeN), .data(plData), .dp(plDp), .signMinus(plMinus));
   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : complete_run
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int i;
      avsAddress   <= a;
      avsWritedata <= wd;
      avsWrite     <= wr;
      avsRead      <= !wr;
      for (i = 0; i < 100; i++)
      begin
         @(posedge clk);
         if (avsWaitrequest === 1'b0) break;
      end
      if (i == 100)
      begin
         n_fail++;
         complete_run();
      end
      rd = avsReaddata;
      avsRead  <= 1'b0;
      avsWrite <= 1'b0;
      @(posedge clk);
   endtask : bus
   task automatic wait_idle();
      int i;
      for (i = 0; i < 3000; i++)
      begin
         @(posedge clk);
         if (busyN === 1'b1) break;
      end
      if (i == 3000)
      begin
         n_fail++;
         complete_run();
      end
   endtask : wait_idle
   task automatic ctrl(input int bitNo);
      bus(1'b1, ADDR_CTRL, 32'h1 << bitNo);
      wait_idle();
   endtask : ctrl
   function automatic logic [63:0] bcd(input longint v);
      logic [63:0] r;
      int          i;
      r = 64'h0;
      for (i = 0; i < 16; i++)
      begin
         r[4*i+:4] = 4'(v % 10);
         v = v / 10;
      end
      return r;
   endfunction : bcd
   function automatic longint quot(input longint n, input longint d);
      longint q;
      int     i;
      q = 0;
      for (i = 0; i < 16; i++)
      begin
         q = q * 10;
         while (n >= d)
         begin
            n = n - d;
            q = q + 1;
         end
         n = n * 10;
      end
      return q;
   endfunction : quot
   task automatic divide(input longint n, input longint d, input logic chk);
      logic [63:0] nb, db;
      nb = bcd(n);
      db = bcd(d);
      bus(1'b1, ADDR_NUMER_LO, nb[31:0]);
      bus(1'b1, ADDR_NUMER_HI, nb[63:32]);
      bus(1'b1, ADDR_DIVIS_LO, db[31:0]);
      bus(1'b1, ADDR_DIVIS_HI, db[63:32]);
      bus(1'b1, ADDR_CTRL, 32'h1 << CTRL_START_BIT);
      // busy register follows the state one edge later
      @(posedge clk);
      `CHK("busy", 1'b0, busyN)
      wait_idle();
      bus(1'b0, ADDR_QUOT_LO, 32'h0);
      q64[31:0] = rd;
      bus(1'b0, ADDR_QUOT_HI, 32'h0);
      q64[63:32] = rd;
      if (chk) `CHK("quotient", bcd(quot(n, d)), q64)
   endtask : divide
   initial
   begin
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      `CHK("waitrequest", 1'b1, avsWaitrequest)
      `CHK("quals", 7'b1011111, {busyN, succ, cZero, cSix, cNine, cTen, cEq})
      bus(1'b0, 8'h3C, 32'h0);
      `CHK("unmapped", 32'h0, rd)
      divide(0, 5, 1'b1);
      `CHK("zero", 1'b1, cZero)
      `CHK("first", 1'b1, firstDig)
      divide(3, 7, 1'b1);
      `CHK("first", 1'b0, firstDig)
      `CHK("blank", 1'b1, blankN)
      divide(19, 2, 1'b1);
      `CHK("nine", 1'b1, sawNine)
      `CHK("success", 1'b1, sawSucc)
      for (k = 0; k < 6; k++)
      begin
         dv = 1 + ({$random(seed)} % 999999);
         nv = {$random(seed)} % (10 * dv);
         divide(nv, dv, 1'b1);
      end
      divide(25, 2, 1'b0);
      `CHK("ten", 1'b1, sawTen)
      sendData <= bcd({$random(seed)} % 99999999);
      sendMinus <= 1'b1;
      sendReq <= 1'b1;
      repeat (4) @(posedge clk);
      `CHK("sign", 1'b0, signN)
      sendReq <= 1'b0;
      @(posedge clk);
      bus(1'b0, ADDR_DIVIS_LO, 32'h0);
      `CHK("divisor", sendData[31:0], rd)
      rmtN <= 1'b0;
      for (k = 1; k < 6; k = k + 2)
      begin
         rmtCode <= 4'(k);
         ctrl(CTRL_CLEAR_BIT);
         `CHK("clear", 1'b1, cZero)
         ctrl(CTRL_ALIGN_BIT);
         `CHK("equal", 1'b0, cEq)
         bus(1'b0, ADDR_STATUS, 32'h0);
         `CHK("count", 4'(k), rd[7:4])
      end
      rmtCode <= 4'h8;
      ctrl(CTRL_CLEAR_BIT);
      ctrl(CTRL_ANNUN_BIT);
      `CHK("six", 1'b0, cSix)
      bus(1'b0, ADDR_STATUS, 32'h0);
      `CHK("annun", COUNT_SIX, rd[7:4])
      rmtN <= 1'b1;
      bus(1'b1, ADDR_MULT, 32'h2);
      ctrl(CTRL_CLEAR_BIT);
      ctrl(CTRL_ALIGN_BIT);
      bus(1'b0, ADDR_STATUS, 32'h0);
      `CHK("local", 4'h2, rd[7:4])
      complete_run();
   end
endmodule : ddn_unit_tb
`default_nettype wire
